/* File: verilog/usc_pkg.sv */
// Constants, register map and state layout of the serial transceiver core.
// Assumes one 100 MHz clock and a plain strobed register port.
`default_nettype none
package usc_pkg;
  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam logic [4:0] OFF_CONTROL_FIRST_REG   = 5'h00;
  localparam logic [4:0] OFF_CONTROL_SECOND_REG   = 5'h04;
  localparam logic [4:0] OFF_BAUD    = 5'h08;
  localparam logic [4:0] OFF_INTERRUPT_FLAG_REG = 5'h0c;
  localparam logic [4:0] OFF_STATUS  = 5'h10;
  localparam logic [4:0] OFF_DBG     = 5'h14;
  localparam logic [4:0] OFF_DATA    = 5'h18;
  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int CA_SOFT_RESET_BIT  = 0;
  localparam int CA_ENABLE = 1;
  localparam int CA_MODE   = 2;
  localparam int CA_COMM_MODE_BIT  = 4;
  localparam int CA_CLOCK_POLARITY_BIT   = 5;
  localparam int CA_IMMEDIATE_OVERFLOW_NOTIFY   = 6;
  localparam int CA_LSBF   = 7;
  localparam int CA_SAMPR  = 8;
  localparam int CA_SAMPLE_ADJUST_FIELD  = 10;
  localparam int CB_CHSIZE = 0;
  localparam int CB_SBMODE = 3;
  localparam int CB_TRANSMITTER_ENABLE_BIT   = 4;
  localparam int CB_RECEIVER_ENABLE_BIT   = 5;
  localparam int CB_PAREN  = 6;
  localparam int CB_PMODE  = 7;
  localparam int IF_DRE    = 0;
  localparam int IF_TXC    = 1;
  localparam int IF_RXC    = 2;
  localparam int ST_PARITY_ERROR_BIT   = 0;
  localparam int ST_FRAME_ERROR_BIT   = 1;
  localparam int ST_OVF    = 2;
  // ********************************************************************
  // Encodings and counts
  // ********************************************************************
  localparam logic [1:0] MODE_EXT = 2'h0;
  localparam logic [1:0] MODE_INT = 2'h1;
  localparam logic [1:0] SAMPR_8  = 2'h1;
  localparam logic [1:0] SAMPR_3  = 2'h2;
  localparam logic [4:0] SPB_16   = 5'h10;
  localparam logic [4:0] SPB_8    = 5'h08;
  localparam logic [4:0] SPB_3    = 5'h03;
  localparam logic [4:0] VOTE16_FIRST = 5'h07;
  localparam logic [4:0] VOTE8_FIRST  = 5'h03;
  localparam logic [4:0] VOTE3_MID    = 5'h02;
  localparam logic [2:0] CHSIZE_9 = 3'h1;
  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_FRAME = 2'b10} usc_rx_t;
  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } usc_req_t;
  typedef struct packed {
    logic [11:0]     control_first_reg;
    logic [7:0]      control_second_reg;
    logic [15:0]     baud;
    logic            dbg;
    logic [2:0]      stat;
    logic            transmit_complete_flag;
    logic [15:0]     rdata;
    logic            holdV;
    logic [8:0]      hold;
    logic            txBusy;
    logic [12:0]     txSh;
    logic [3:0]      txLeft;
    logic            txd;
    logic [4:0]      txSmp;
    logic [15:0]     baudCnt;
    logic            xckOut;
    logic            xckS1;
    logic            xckS2;
    logic            xckS3;
    logic            rxS1;
    logic            rxS2;
    usc_rx_t         rxSt;
    logic [4:0]      rxSmp;
    logic [1:0]      rxVote;
    logic [3:0]      rxBit;
    logic [9:0]      rxSh;
    logic [1:0][9:0] fifo;
    logic            fHead;
    logic [1:0]      fCnt;
  } usc_state_t;
  localparam usc_state_t ST_RST = '{rxSt: RX_IDLE, txd: 1'b1, xckS1: 1'b1, xckS2: 1'b1,
                                    xckS3: 1'b1, rxS1: 1'b1, rxS2: 1'b1, default: '0};
endpackage
`default_nettype wire

/* File: verilog/usc_core.sv */
// Serial transceiver core: registers, baud generator, transmitter, receiver.
// Assumes rxd and xckIn come from pins; the register port shares ref_clk.
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module usc_core (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              clkEn,
  input  wire usc_pkg::usc_req_t regReq,
  output logic [15:0]            regRdata,
  output logic                   txd,
  input  wire logic              rxd,
  input  wire logic              xckIn,
  output logic                   xckOut,
  output logic                   xckOe
);
  // ********************************************************************
  // Decoding helpers
  // ********************************************************************
  function automatic logic [3:0] dataLen(input logic [2:0] chsize);
    if (chsize == usc_pkg::CHSIZE_9) begin
      return 4'h9;
    end
    if (chsize >= 3'h5) begin
      return {1'b0, chsize};
    end
    return 4'h8;
  endfunction

  function automatic logic [4:0] samplesPerBit(input logic [1:0] sampr);
    case (sampr)
      usc_pkg::SAMPR_8: return usc_pkg::SPB_8;
      usc_pkg::SAMPR_3: return usc_pkg::SPB_3;
      default:          return usc_pkg::SPB_16;
    endcase
  endfunction

  function automatic logic [1:0] voteWeight(input logic [1:0] sampr, input logic [4:0] idx);
    case (sampr)
      usc_pkg::SAMPR_8: return {1'b0, idx >= usc_pkg::VOTE8_FIRST
                                && idx <= usc_pkg::VOTE8_FIRST + 5'h2};
      usc_pkg::SAMPR_3: return (idx == usc_pkg::VOTE3_MID) ? 2'h3 : 2'h0;
      default:          return {1'b0, idx >= usc_pkg::VOTE16_FIRST
                                && idx <= usc_pkg::VOTE16_FIRST + 5'h2};
    endcase
  endfunction

  function automatic logic [8:0] orderBits(input logic [8:0] d, input logic [3:0] len,
                                           input logic rev);
    logic [8:0] r;
    r = '0;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < len) begin
        r[i] = rev ? d[4'(len - 4'h1 - 4'(i))] : d[i];
      end
    end
    return r;
  endfunction

  function automatic logic parityOf(input logic [8:0] d);
    return ^d;
  endfunction

  function automatic logic [12:0] buildFrame(input logic [8:0] d, input logic [3:0] len,
                                             input logic lsbF, input logic parEn,
                                             input logic pOdd);
    logic [8:0]  o;
    logic [12:0] f;
    o = orderBits(d, len, !lsbF);
    f = '1;
    f[0] = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < len) begin
        f[i + 1] = o[i];
      end
    end
    if (parEn) begin
      f[len + 4'h1] = parityOf(orderBits(d, len, 1'b0)) ^ pOdd;
    end
    return f;
  endfunction

  // ********************************************************************
  // State and working signals
  // ********************************************************************
  usc_pkg::usc_state_t state_r;
  usc_pkg::usc_state_t state_nxt;
  logic                en;
  logic                syncMode;
  logic                intClk;
  logic [15:0]         div;
  logic                tick;
  logic                rise;
  logic                fall;
  logic                chgEdge;
  logic                smpEdge;
  logic                sampleTick;
  logic [4:0]          spb;
  logic                txBitEdge;
  logic                rxOn;
  logic                push;
  logic                pop;
  logic                bitDone;
  logic                bitVal;
  logic [3:0]          dlen;
  logic [3:0]          nBits;
  logic [3:0]          flen;
  logic                parEn;
  logic                pOdd;
  logic                lsbF;
  logic [8:0]          receive_holding_reg;
  logic [12:0]         frame;
  logic [1:0]          voteSum;
  logic                swReset;

  always_comb begin
    state_nxt = state_r;
    // ******************************************************************
    // Pin synchronisers
    // ******************************************************************
    state_nxt.rxS1  = rxd;
    state_nxt.rxS2  = state_r.rxS1;
    state_nxt.xckS1 = xckIn;
    state_nxt.xckS2 = state_r.xckS1;
    state_nxt.xckS3 = state_r.xckS2;
    // ******************************************************************
    // Configuration decode and clock generation
    // ******************************************************************
    en       = state_r.control_first_reg[usc_pkg::CA_ENABLE];
    syncMode = state_r.control_first_reg[usc_pkg::CA_COMM_MODE_BIT];
    intClk   = state_r.control_first_reg[usc_pkg::CA_MODE +: 2] == usc_pkg::MODE_INT;
    lsbF     = state_r.control_first_reg[usc_pkg::CA_LSBF];
    parEn    = state_r.control_second_reg[usc_pkg::CB_PAREN];
    pOdd     = state_r.control_second_reg[usc_pkg::CB_PMODE];
    dlen     = dataLen(state_r.control_second_reg[usc_pkg::CB_CHSIZE +: 3]);
    nBits    = dlen + {3'h0, parEn};
    flen     = 4'h2 + nBits + {3'h0, state_r.control_second_reg[usc_pkg::CB_SBMODE]};
    spb      = samplesPerBit(state_r.control_first_reg[usc_pkg::CA_SAMPR +: 2]);
    div      = syncMode ? {8'h00, state_r.baud[7:0]} : state_r.baud;
    tick     = en && intClk && state_r.baudCnt == div;
    state_nxt.baudCnt = (!en || tick) ? 16'h0000 : state_r.baudCnt + 16'h0001;
    if (!en || !syncMode || !intClk) begin
      state_nxt.xckOut = 1'b0;
    end else if (tick) begin
      state_nxt.xckOut = ~state_r.xckOut;
    end
    if (intClk) begin
      rise = tick && !state_r.xckOut;
      fall = tick && state_r.xckOut;
    end else begin
      rise = state_r.xckS2 && !state_r.xckS3;
      fall = !state_r.xckS2 && state_r.xckS3;
    end
    chgEdge    = state_r.control_first_reg[usc_pkg::CA_CLOCK_POLARITY_BIT] ? fall : rise;
    smpEdge    = state_r.control_first_reg[usc_pkg::CA_CLOCK_POLARITY_BIT] ? rise : fall;
    sampleTick = en && (intClk ? tick : rise);
    if (sampleTick) begin
      state_nxt.txSmp = (state_r.txSmp >= spb - 5'h1) ? 5'h00 : state_r.txSmp + 5'h01;
    end
    txBitEdge = syncMode ? (en && chgEdge)
                         : (sampleTick && state_r.txSmp >= spb - 5'h1);
    // ******************************************************************
    // Register port
    // ******************************************************************
    swReset = 1'b0;
    pop     = 1'b0;
    if (regReq.wr) begin
      case (regReq.addr)
        usc_pkg::OFF_CONTROL_FIRST_REG: begin
          if (regReq.wdata[usc_pkg::CA_SOFT_RESET_BIT]) begin
            swReset = 1'b1;
          end else if (en) begin
            state_nxt.control_first_reg[usc_pkg::CA_ENABLE] = regReq.wdata[usc_pkg::CA_ENABLE];
          end else begin
            state_nxt.control_first_reg = {regReq.wdata[11:1], 1'b0};
          end
        end
        usc_pkg::OFF_CONTROL_SECOND_REG: begin
          if (en) begin
            state_nxt.control_second_reg[usc_pkg::CB_TRANSMITTER_ENABLE_BIT] = regReq.wdata[usc_pkg::CB_TRANSMITTER_ENABLE_BIT];
            state_nxt.control_second_reg[usc_pkg::CB_RECEIVER_ENABLE_BIT] = regReq.wdata[usc_pkg::CB_RECEIVER_ENABLE_BIT];
          end else begin
            state_nxt.control_second_reg = regReq.wdata[7:0];
          end
        end
        usc_pkg::OFF_BAUD: begin
          if (!en) begin
            state_nxt.baud = regReq.wdata;
          end
        end
        usc_pkg::OFF_INTERRUPT_FLAG_REG: begin
          if (regReq.wdata[usc_pkg::IF_TXC]) begin
            state_nxt.transmit_complete_flag = 1'b0;
          end
        end
        usc_pkg::OFF_STATUS: state_nxt.stat = state_r.stat & ~regReq.wdata[2:0];
        usc_pkg::OFF_DBG:    state_nxt.dbg = regReq.wdata[0];
        usc_pkg::OFF_DATA: begin
          state_nxt.hold  = regReq.wdata[8:0];
          state_nxt.holdV = 1'b1;
          state_nxt.transmit_complete_flag   = 1'b0;
        end
        default: ;
      endcase
    end
    if (regReq.rd) begin
      case (regReq.addr)
        usc_pkg::OFF_CONTROL_FIRST_REG:   state_nxt.rdata = {4'h0, state_r.control_first_reg};
        usc_pkg::OFF_CONTROL_SECOND_REG:   state_nxt.rdata = {8'h00, state_r.control_second_reg};
        usc_pkg::OFF_BAUD:    state_nxt.rdata = state_r.baud;
        usc_pkg::OFF_INTERRUPT_FLAG_REG: state_nxt.rdata = {13'h0000, state_r.fCnt != 2'h0,
                                                 state_r.transmit_complete_flag, !state_r.holdV};
        usc_pkg::OFF_STATUS:  state_nxt.rdata = {13'h0000, state_r.stat};
        usc_pkg::OFF_DBG:     state_nxt.rdata = {15'h0000, state_r.dbg};
        usc_pkg::OFF_DATA: begin
          state_nxt.rdata = {7'h00, state_r.fifo[state_r.fHead][8:0]};
          pop = state_r.fCnt != 2'h0;
        end
        default:              state_nxt.rdata = 16'h0000;
      endcase
    end
    // ******************************************************************
    // Transmitter
    // ******************************************************************
    frame = buildFrame(state_r.hold, dlen, lsbF, parEn, pOdd);
    if (!en) begin
      state_nxt.txBusy = 1'b0;
      state_nxt.txLeft = 4'h0;
      state_nxt.txd    = 1'b1;
    end else if ((state_r.control_second_reg[usc_pkg::CB_TRANSMITTER_ENABLE_BIT] || state_r.txBusy) && txBitEdge) begin
      if (state_r.txLeft != 4'h0) begin
        state_nxt.txd    = state_r.txSh[0];
        state_nxt.txSh   = {1'b1, state_r.txSh[12:1]};
        state_nxt.txLeft = state_r.txLeft - 4'h1;
      end else if (state_r.holdV) begin
        state_nxt.txd    = frame[0];
        state_nxt.txSh   = {1'b1, frame[12:1]};
        state_nxt.txLeft = flen - 4'h1;
        state_nxt.holdV  = 1'b0;
        state_nxt.txBusy = 1'b1;
      end else begin
        state_nxt.transmit_complete_flag    = state_r.transmit_complete_flag | state_r.txBusy;
        state_nxt.txBusy = 1'b0;
        state_nxt.txd    = 1'b1;
      end
    end
    // ******************************************************************
    // Receiver
    // ******************************************************************
    rxOn    = en && state_r.control_second_reg[usc_pkg::CB_RECEIVER_ENABLE_BIT];
    push    = 1'b0;
    voteSum = state_r.rxVote + (state_r.rxS2 ? voteWeight(state_r.control_first_reg[usc_pkg::CA_SAMPR +: 2],
                                          state_r.rxSmp + 5'h01) : 2'h0);
    if (syncMode) begin
      bitDone = smpEdge;
      bitVal  = state_r.rxS2;
    end else begin
      bitDone = sampleTick && state_r.rxSmp + 5'h01 >= spb;
      bitVal  = voteSum >= 2'h2;
    end
    receive_holding_reg = orderBits(state_r.rxSh[8:0], dlen, !lsbF);
    if (pop) begin
      state_nxt.fHead = ~state_r.fHead;
      state_nxt.fCnt  = state_r.fCnt - 2'h1;
      if (state_r.fCnt == 2'h2 && state_r.fifo[~state_r.fHead][9]) begin
        state_nxt.stat[usc_pkg::ST_OVF] = 1'b1;
        state_nxt.fifo[~state_r.fHead][9] = 1'b0;
      end
    end
    case (state_r.rxSt)
      usc_pkg::RX_IDLE: begin
        state_nxt.rxSmp  = 5'h00;
        state_nxt.rxVote = 2'h0;
        if (rxOn && !state_r.rxS2 && (!syncMode || smpEdge)) begin
          state_nxt.rxSt  = usc_pkg::RX_FRAME;
          state_nxt.rxBit = syncMode ? 4'h1 : 4'h0;
        end
      end
      usc_pkg::RX_FRAME: begin
        if (sampleTick && !syncMode) begin
          state_nxt.rxSmp  = bitDone ? 5'h00 : state_r.rxSmp + 5'h01;
          state_nxt.rxVote = bitDone ? 2'h0 : voteSum;
        end
        if (bitDone) begin
          if (state_r.rxBit == 4'h0 && bitVal) begin
            state_nxt.rxSt = usc_pkg::RX_IDLE;
          end else if (state_r.rxBit == 4'h0) begin
            state_nxt.rxBit = 4'h1;
          end else if (state_r.rxBit <= nBits) begin
            state_nxt.rxSh[state_r.rxBit - 4'h1] = bitVal;
            state_nxt.rxBit = state_r.rxBit + 4'h1;
          end else begin
            state_nxt.rxSt = usc_pkg::RX_IDLE;
            push = 1'b1;
            if (!bitVal) begin
              state_nxt.stat[usc_pkg::ST_FRAME_ERROR_BIT] = 1'b1;
            end
            if (parEn && (parityOf(receive_holding_reg) ^ pOdd) != state_r.rxSh[dlen]) begin
              state_nxt.stat[usc_pkg::ST_PARITY_ERROR_BIT] = 1'b1;
            end
          end
        end
      end
      default: state_nxt.rxSt = usc_pkg::RX_IDLE;
    endcase
    if (push) begin
      if (state_nxt.fCnt == 2'h2) begin
        if (state_r.control_first_reg[usc_pkg::CA_IMMEDIATE_OVERFLOW_NOTIFY]) begin
          state_nxt.stat[usc_pkg::ST_OVF] = 1'b1;
        end else begin
          state_nxt.fifo[~state_nxt.fHead][9] = 1'b1;
        end
      end else begin
        state_nxt.fifo[state_nxt.fHead ^ state_nxt.fCnt[0]] = {1'b0, receive_holding_reg};
        state_nxt.fCnt = state_nxt.fCnt + 2'h1;
      end
    end
    if (!rxOn) begin
      state_nxt.rxSt  = usc_pkg::RX_IDLE;
      state_nxt.fCnt  = 2'h0;
      state_nxt.fHead = 1'b0;
      state_nxt.fifo  = '0;
      state_nxt.stat  = 3'h0;
    end
    if (swReset) begin
      state_nxt     = usc_pkg::ST_RST;
      state_nxt.dbg = state_r.dbg;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= usc_pkg::ST_RST;
    end else if (clkEn) begin
      state_r <= state_nxt;
    end
  end

  assign regRdata = state_r.rdata;
  assign txd      = state_r.txd;
  assign xckOut   = state_r.xckOut;
  assign xckOe    = en && syncMode && intClk;

  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_enable_write: assert property (clkEn && regReq.wr && regReq.addr == usc_pkg::OFF_CONTROL_FIRST_REG
      && !regReq.wdata[usc_pkg::CA_SOFT_RESET_BIT] |=> en == $past(regReq.wdata[usc_pkg::CA_ENABLE]))
    else $error("Enable bit did not follow the write.");
  chk_soft_reset_regs: assert property (clkEn && regReq.wr && regReq.addr == usc_pkg::OFF_CONTROL_FIRST_REG
      && regReq.wdata[usc_pkg::CA_SOFT_RESET_BIT] |=> !en && state_r.baud == 16'h0000
      && state_r.dbg == $past(state_r.dbg))
    else $error("Soft reset left state behind.");
  chk_baud_protect: assert property (clkEn && en && regReq.wr && regReq.addr == usc_pkg::OFF_BAUD
      |=> state_r.baud == $past(state_r.baud))
    else $error("Baud changed while enabled.");
  chk_data_write_full: assert property (clkEn && regReq.wr && regReq.addr == usc_pkg::OFF_DATA
      |=> state_r.holdV && state_r.hold == $past(regReq.wdata[8:0]))
    else $error("Data write did not load the holding stage.");
  chk_txc_when_done: assert property ($rose(state_r.transmit_complete_flag) |-> !state_r.holdV && txd
      && !state_r.txBusy)
    else $error("Transmit complete raised too early.");
  chk_idle_line_high: assert property (!state_r.txBusy |-> txd)
    else $error("Line not high while idle.");
  chk_rx_disable_flush: assert property (clkEn && !rxOn |=> state_r.fCnt == 2'h0
      && state_r.stat == 3'h0 && state_r.rxSt == usc_pkg::RX_IDLE)
    else $error("Receiver disable did not flush.");
  chk_ovf_immediate: assert property (clkEn && rxOn && push && !pop && state_r.fCnt == 2'h2
      && state_r.control_first_reg[usc_pkg::CA_IMMEDIATE_OVERFLOW_NOTIFY] && !swReset |=> state_r.stat[usc_pkg::ST_OVF])
    else $error("Overflow not flagged at once.");
  chk_rxc_only_by_read: assert property ($fell(state_r.fCnt != 2'h0) |-> $past(pop || !rxOn
      || swReset))
    else $error("Receive complete cleared without a read.");

  cov_tx_frame: cover property ($rose(state_r.transmit_complete_flag));
  cov_rx_store: cover property (clkEn && push && state_r.fCnt == 2'h1);
  cov_overflow: cover property (clkEn && push && state_r.fCnt == 2'h2 && !pop);
  cov_false_start: cover property (clkEn && state_r.rxSt == usc_pkg::RX_FRAME && bitDone
      && state_r.rxBit == 4'h0 && bitVal);
endmodule // usc_core
`default_nettype wire

/* File: testbench/usc_remote.sv */
// Remote serial transceiver model for the line side of the core.
// Assumes 8N1 asynchronous frames of BIT_CYC ref_clk cycles per bit.
`timescale 1ns/1ps
`default_nettype none
module usc_remote #(
  parameter int BIT_CYC = 16
) (
  input  wire logic ref_clk,
  input  wire logic txd,
  output var  logic rxd
);
  initial rxd = 1'b1;
  // Sends one frame at the exact nominal rate.
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk) rxd <= f[i];
      repeat (BIT_CYC - 1) @(posedge ref_clk);
    end
  endtask
  // Captures the eight data bits of one frame in the middle of each data bit.
  task automatic get(output logic [7:0] d);
    @(negedge txd);
    repeat (BIT_CYC / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge ref_clk);
      d[i] = txd;
    end
  endtask
endmodule // usc_remote
`default_nettype wire

/* File: testbench/usart_core_tx_rx_tb_top.sv */
// Self-checking bench of the serial transceiver core.
// Assumes the remote model on the line and a 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin failures++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module usart_core_tx_rx_tb_top;
  logic              ref_clk = 1'b0;
  logic              rst_n = 1'b0;
  usc_pkg::usc_req_t regReq = '0;
  logic [15:0]       regRdata;
  logic              txd;
  logic              rxd;
  logic              xckOut;
  logic              xckOe;
  logic [7:0]        got;
  logic [15:0]       rv;
  int                failures = 0;
  int                num_checks = 0;
  int                cycles = 0;
  usc_core u_usc_core (.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(1'b1), .regReq(regReq),
    .regRdata(regRdata), .txd(txd), .rxd(rxd), .xckIn(xckOut), .xckOut(xckOut), .xckOe(xckOe));
  usc_remote u_usc_remote (.ref_clk(ref_clk), .txd(txd), .rxd(rxd));
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      test_done();
    end
  end
  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk) regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk) regReq <= '0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge ref_clk) regReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk) regReq <= '0;
    #1 rv = regRdata;
  endtask
  task automatic test_done;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_protect;
    wr(usc_pkg::OFF_CONTROL_SECOND_REG, 16'h0030);
    wr(usc_pkg::OFF_BAUD, 16'h0000);
    wr(usc_pkg::OFF_CONTROL_FIRST_REG, 16'h0086);
    wr(usc_pkg::OFF_BAUD, 16'h1234);
    rd(usc_pkg::OFF_BAUD);
    `CHK("baud", 16'h0000, rv)
    rd(usc_pkg::OFF_CONTROL_FIRST_REG);
    `CHK("control_first_reg", 16'h0086, rv)
  endtask
  task automatic t_tx;
    rd(usc_pkg::OFF_INTERRUPT_FLAG_REG);
    `CHK("dreBefore", 1'b1, rv[usc_pkg::IF_DRE])
    fork
      u_usc_remote.get(got);
      wr(usc_pkg::OFF_DATA, 16'h00a5);
    join
    `CHK("txByte", 8'ha5, got)
    repeat (40) @(posedge ref_clk);
    rd(usc_pkg::OFF_INTERRUPT_FLAG_REG);
    `CHK("txcDre", 3'h3, rv[2:0])
  endtask
  task automatic t_rx;
    u_usc_remote.send(8'h3c);
    repeat (8) @(posedge ref_clk);
    rd(usc_pkg::OFF_INTERRUPT_FLAG_REG);
    `CHK("rxcSet", 1'b1, rv[usc_pkg::IF_RXC])
    rd(usc_pkg::OFF_DATA);
    `CHK("receive_holding_reg", 16'h003c, rv)
    rd(usc_pkg::OFF_INTERRUPT_FLAG_REG);
    `CHK("rxcClr", 1'b0, rv[usc_pkg::IF_RXC])
  endtask
  task automatic t_ovf;
    u_usc_remote.send(8'h11);
    u_usc_remote.send(8'h22);
    u_usc_remote.send(8'h33);
    repeat (8) @(posedge ref_clk);
    rd(usc_pkg::OFF_STATUS);
    `CHK("ovfLate", 1'b0, rv[usc_pkg::ST_OVF])
    rd(usc_pkg::OFF_DATA);
    `CHK("oldest", 16'h0011, rv)
    rd(usc_pkg::OFF_STATUS);
    `CHK("ovfShown", 1'b1, rv[usc_pkg::ST_OVF])
    wr(usc_pkg::OFF_STATUS, 16'h0004);
    rd(usc_pkg::OFF_STATUS);
    `CHK("ovfW1c", 1'b0, rv[usc_pkg::ST_OVF])
    wr(usc_pkg::OFF_CONTROL_SECOND_REG, 16'h0010);
    rd(usc_pkg::OFF_INTERRUPT_FLAG_REG);
    `CHK("flush", 1'b0, rv[usc_pkg::IF_RXC])
  endtask
  task automatic t_soft_reset_bit;
    wr(usc_pkg::OFF_CONTROL_FIRST_REG, 16'h0001);
    rd(usc_pkg::OFF_CONTROL_SECOND_REG);
    `CHK("control_second_reg", 16'h0000, rv)
    wr(usc_pkg::OFF_CONTROL_FIRST_REG, 16'h0016);
    #1 `CHK("xckOe", 1'b1, xckOe)
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_protect();
    t_tx();
    t_rx();
    t_ovf();
    t_soft_reset_bit();
    test_done();
  end
endmodule // usart_core_tx_rx_tb_top
`default_nettype wire
